//--- design/otgsw_edge_det.sv
/*
 * otgsw_edge_det: per-bit rising and falling edge pulses of level inputs.
 * assumes: inputs synchronous to clk; no edge reported in the first
 * cycle after reset while the history is captured.
 */
`timescale 1ns/1ps
module otgsw_edge_det #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels in
    input wire logic [WIDTH-1:0] level,
    // one-cycle edge pulses
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic armed;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            armed <= 1'b0;
        else
            armed <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prev <= '0;
        else
            prev <= level;
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            assign rise[i] = armed & level[i] & ~prev[i];
            assign fall[i] = armed & ~level[i] & prev[i];
        end
    endgenerate

endmodule : otgsw_edge_det

//--- design/otgsw_regs.sv
/*
 * otgsw_regs: status, control and interrupt registers of the on-the-go
 * power-switch subsystem, with switch enables and an interrupt pin.
 * assumes: the serial-interface engine presents one-cycle read and write
 * strobes with an 8-bit register address; analog status inputs are
 * synchronous to clk.
 */
// Notes on behaviour
// - switch-2 health bit reads zero on failed start-up or current limit
// - vbus interrupt flag sets when an enabled vbus edge raises an interrupt
// - writing one to limit-double bit doubles switch-3 current limit
// - vbus presence bit reads one while a valid source sits on vbus
// - rising-edge enable raises an interrupt when a charger connects
// - falling-edge enable raises an interrupt when a charger disconnects
// - switch-1 fault enable raises an interrupt on switch-1 over-current
// - switch-2 fault enable raises an interrupt on switch-2 over-current
// - vbus interrupts reach the pin only while the vbus unmask bit is one
// - read-only eight-bit source address names the pending interrupt
// - each switch is on while its enable bit is one, else off
// - switch-1 health bit reads zero on failed start-up or current limit
`timescale 1ns/1ps
module otgsw_regs
    import otgsw_pkg::*;
#(
    parameter logic [7:0] SOURCE_ADDR = 8'hb0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire otgsw_pkg::otgsw_req_s req,
    output logic [7:0] rdata,
    // analog status
    input wire logic vbus_valid,
    input wire otgsw_pkg::otgsw_sw_stat_s sw1_stat,
    input wire otgsw_pkg::otgsw_sw_stat_s sw2_stat,
    // switch controls
    output logic switch1_on,
    output logic switch2_on,
    output logic switch3_on,
    output logic switch3_limit_double,
    // interrupt pin
    output logic irq_n
);
    import otgsw_pkg::*;

    logic [7:0] irq_enable;
    logic vbus_present;
    logic switch1_healthy;
    logic switch2_healthy;
    logic vbus_irq_flag;
    logic sw1_fault_flag;
    logic sw2_fault_flag;
    logic [7:0] irq_source_addr;
    logic [2:0] rise;
    logic [2:0] fall;
    logic wr_ctrl;
    logic wr_en;
    logic rd_ctrl;
    logic vbus_event;
    logic sw1_event;
    logic sw2_event;
    logic pending;
    logic [7:0] status_view;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign wr_ctrl = req.wr && (req.addr == OTGSW_ADDR_STATUS_CTRL);
    assign wr_en = req.wr && (req.addr == OTGSW_ADDR_IRQ_ENABLE);
    assign rd_ctrl = req.rd && (req.addr == OTGSW_ADDR_STATUS_CTRL);

    // ------------------------------------------------------------
    // live status
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            vbus_present <= 1'b0;
            switch1_healthy <= 1'b0;
            switch2_healthy <= 1'b0;
        end
        else
        begin
            vbus_present <= vbus_valid;
            switch1_healthy <= sw1_stat.startup_ok & ~sw1_stat.in_limit;
            switch2_healthy <= sw2_stat.startup_ok & ~sw2_stat.in_limit;
        end
    end

    // vbus presence plus the two current-limit levels
    otgsw_edge_det #(
        .WIDTH(3)
    ) u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level({sw2_stat.in_limit, sw1_stat.in_limit, vbus_present}),
        .rise(rise),
        .fall(fall)
    );

    assign vbus_event = (rise[0] & irq_enable[OTGSW_BIT_VBUS_RISE_IRQ_EN])
        | (fall[0] & irq_enable[OTGSW_BIT_VBUS_FALL_IRQ_EN]);
    assign sw1_event = rise[1] & irq_enable[OTGSW_BIT_SWITCH1_FAULT_IRQ_EN];
    assign sw2_event = rise[2] & irq_enable[OTGSW_BIT_SWITCH2_FAULT_IRQ_EN];

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            switch1_on <= OTGSW_RST_STATUS_CTRL[OTGSW_BIT_SWITCH1_ON];
            switch2_on <= OTGSW_RST_STATUS_CTRL[OTGSW_BIT_SWITCH2_ON];
            switch3_on <= OTGSW_RST_STATUS_CTRL[OTGSW_BIT_SWITCH3_ON];
            switch3_limit_double <= OTGSW_RST_STATUS_CTRL[OTGSW_BIT_SWITCH3_LIMIT_DOUBLE];
        end
        else if (wr_ctrl)
        begin
            switch1_on <= req.wdata[OTGSW_BIT_SWITCH1_ON];
            switch2_on <= req.wdata[OTGSW_BIT_SWITCH2_ON];
            switch3_on <= req.wdata[OTGSW_BIT_SWITCH3_ON];
            switch3_limit_double <= req.wdata[OTGSW_BIT_SWITCH3_LIMIT_DOUBLE];
        end
    end

    // ------------------------------------------------------------
    // interrupt enable register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_enable <= OTGSW_RST_IRQ_ENABLE;
        else if (wr_en)
            irq_enable <= req.wdata & OTGSW_IRQ_ENABLE_WMASK;
    end

    // ------------------------------------------------------------
    // sticky flags, cleared by reading the status register; set wins
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            vbus_irq_flag <= 1'b0;
        else if (vbus_event)
            vbus_irq_flag <= 1'b1;
        else if (rd_ctrl)
            vbus_irq_flag <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sw1_fault_flag <= 1'b0;
        else if (sw1_event)
            sw1_fault_flag <= 1'b1;
        else if (rd_ctrl)
            sw1_fault_flag <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sw2_fault_flag <= 1'b0;
        else if (sw2_event)
            sw2_fault_flag <= 1'b1;
        else if (rd_ctrl)
            sw2_fault_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // interrupt pin and source address
    // ------------------------------------------------------------
    assign pending = (vbus_irq_flag & irq_enable[OTGSW_BIT_VBUS_IRQ_UNMASK])
        | sw1_fault_flag | sw2_fault_flag;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_n <= 1'b1;
            irq_source_addr <= OTGSW_SRC_NONE;
        end
        else
        begin
            irq_n <= ~pending;
            irq_source_addr <= pending ? SOURCE_ADDR : OTGSW_SRC_NONE;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb
    begin
        status_view = '0;
        status_view[OTGSW_BIT_SWITCH1_ON] = switch1_on;
        status_view[OTGSW_BIT_SWITCH2_ON] = switch2_on;
        status_view[OTGSW_BIT_SWITCH3_ON] = switch3_on;
        status_view[OTGSW_BIT_SWITCH1_HEALTHY] = switch1_healthy;
        status_view[OTGSW_BIT_SWITCH2_HEALTHY] = switch2_healthy;
        status_view[OTGSW_BIT_VBUS_IRQ_FLAG] = vbus_irq_flag;
        status_view[OTGSW_BIT_SWITCH3_LIMIT_DOUBLE] = switch3_limit_double;
        status_view[OTGSW_BIT_VBUS_PRESENT] = vbus_present;
    end

    always_comb
    begin
        next_rdata = 8'h00;
        unique case (req.addr)
            OTGSW_ADDR_STATUS_CTRL: next_rdata = status_view;
            OTGSW_ADDR_IRQ_ENABLE: next_rdata = irq_enable;
            OTGSW_ADDR_IRQ_SOURCE: next_rdata = irq_source_addr;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (req.rd)
            rdata <= next_rdata;
    end

endmodule : otgsw_regs

//--- inc/otgsw_pkg.sv
/*
 * otgsw_pkg: register map, field positions and reset values of the
 * on-the-go switch status and interrupt register bank.
 * assumes: 8-bit register space reached through the serial-interface
 * register port of the device.
 */
package otgsw_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OTGSW_ADDR_STATUS_CTRL = 8'hb0;
    localparam logic [7:0] OTGSW_ADDR_IRQ_ENABLE = 8'hb2;
    localparam logic [7:0] OTGSW_ADDR_IRQ_SOURCE = 8'hc1;

    // ------------------------------------------------------------
    // otg_switch_status_ctrl fields
    // ------------------------------------------------------------
    localparam int OTGSW_BIT_SWITCH1_ON = 7;
    localparam int OTGSW_BIT_SWITCH2_ON = 6;
    localparam int OTGSW_BIT_SWITCH3_ON = 5;
    localparam int OTGSW_BIT_SWITCH1_HEALTHY = 4;
    localparam int OTGSW_BIT_SWITCH2_HEALTHY = 3;
    localparam int OTGSW_BIT_VBUS_IRQ_FLAG = 2;
    localparam int OTGSW_BIT_SWITCH3_LIMIT_DOUBLE = 1;
    localparam int OTGSW_BIT_VBUS_PRESENT = 0;

    // ------------------------------------------------------------
    // otg_interrupt_enable fields
    // ------------------------------------------------------------
    localparam int OTGSW_BIT_VBUS_RISE_IRQ_EN = 7;
    localparam int OTGSW_BIT_VBUS_FALL_IRQ_EN = 6;
    localparam int OTGSW_BIT_SWITCH1_FAULT_IRQ_EN = 3;
    localparam int OTGSW_BIT_SWITCH2_FAULT_IRQ_EN = 2;
    localparam int OTGSW_BIT_VBUS_IRQ_UNMASK = 1;
    localparam logic [7:0] OTGSW_IRQ_ENABLE_WMASK = 8'hce;

    // ------------------------------------------------------------
    // reset values and source code
    // ------------------------------------------------------------
    localparam logic [7:0] OTGSW_RST_STATUS_CTRL = 8'h00;
    localparam logic [7:0] OTGSW_RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OTGSW_SRC_NONE = 8'h00;

    // ------------------------------------------------------------
    // register port carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } otgsw_req_s;

    // analog status from one power switch
    typedef struct packed {
        logic startup_ok;
        logic in_limit;
    } otgsw_sw_stat_s;

endpackage : otgsw_pkg

//--- verif/otgsw_host.sv
/* otgsw_host: register-port master in place of the serial engine.
   assumes: strobes sampled at rising clk edges. */
`timescale 1ns/1ps
module otgsw_host
    import otgsw_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output otgsw_pkg::otgsw_req_s req,
    input wire logic [7:0] rdata
);
    import otgsw_pkg::*;
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask : rd
endmodule : otgsw_host

//--- verif/otgsw_regs_assertions.sv
/* otgsw_regs_assertions: port timing checks of the switch register bank.
   assumes: bound into otgsw_regs; strobes are one-cycle pulses. */
`timescale 1ns/1ps
module otgsw_regs_assertions
    import otgsw_pkg::*;
#(
    parameter logic [7:0] SOURCE_ADDR = 8'hb0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire otgsw_pkg::otgsw_req_s req,
    input wire logic [7:0] rdata,
    input wire logic vbus_valid,
    input wire otgsw_pkg::otgsw_sw_stat_s sw1_stat,
    input wire otgsw_pkg::otgsw_sw_stat_s sw2_stat,
    input wire logic switch1_on,
    input wire logic switch2_on,
    input wire logic switch3_on,
    input wire logic switch3_limit_double,
    input wire logic irq_n
);
    import otgsw_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] en;
    logic [1:0] hl;
    logic rd0, rdc, quiet;
    assign rd0 = req.rd && req.addr == OTGSW_ADDR_STATUS_CTRL;
    assign rdc = req.rd && req.addr == OTGSW_ADDR_IRQ_SOURCE;
    assign quiet = !req.rd && !req.wr;
    assign hl = {sw1_stat.startup_ok & ~sw1_stat.in_limit,
        sw2_stat.startup_ok & ~sw2_stat.in_limit};
    // shadow of the enable register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            en <= 8'h00;
        else if (req.wr && req.addr == OTGSW_ADDR_IRQ_ENABLE)
            en <= req.wdata & OTGSW_IRQ_ENABLE_WMASK;
    end
    property p_ctrl;
        req.wr && req.addr == OTGSW_ADDR_STATUS_CTRL |=> {switch1_on, switch2_on, switch3_on,
            switch3_limit_double} == {$past(req.wdata[7:5]), $past(req.wdata[1])};
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("switch controls wrong");
    property p_unmap;
        req.rd && req.addr[1:0] == 2'b11 |=> rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_resv;
        req.rd && req.addr == OTGSW_ADDR_IRQ_ENABLE |=> (rdata & ~OTGSW_IRQ_ENABLE_WMASK) == 8'h00;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_src;
        rdc |=> rdata == ($past(irq_n) ? 8'h00 : SOURCE_ADDR);
    endproperty
    a_src: assert property (p_src) else $error("source address wrong");
    property p_pres;
        rd0 && $past(rst_n) |=> rdata[0] == $past(vbus_valid, 2);
    endproperty
    a_pres: assert property (p_pres) else $error("presence bit wrong");
    property p_health;
        rd0 && $past(rst_n) |=> rdata[4:3] == $past(hl, 2);
    endproperty
    a_health: assert property (p_health) else $error("health bits wrong");
    property p_vbus;
        $changed(vbus_valid) && (vbus_valid ? en[7] : en[6]) && en[1] && quiet
            && $past(rst_n, 3) |-> ##[1:6] (!irq_n || !quiet);
    endproperty
    a_vbus: assert property (p_vbus) else $error("vbus edge gave no irq");
    property p_fault;
        ($rose(sw1_stat.in_limit) && en[3] || $rose(sw2_stat.in_limit) && en[2]) && quiet
            && $past(rst_n, 2) |-> ##[1:4] (!irq_n || !quiet);
    endproperty
    a_fault: assert property (p_fault) else $error("fault gave no irq");
    property p_mask;
        rd0 && en[3:1] == 3'b000 ##1 en[3:1] == 3'b000 |=> irq_n || en[3:1] != 3'b000;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq raised");
    c_irq: cover property ($fell(irq_n));
    c_src: cover property (rdc && !irq_n);
    c_fault: cover property ($rose(sw2_stat.in_limit) && en[2]);
endmodule : otgsw_regs_assertions
bind otgsw_regs otgsw_regs_assertions #(.SOURCE_ADDR(SOURCE_ADDR)) chk (.*);

//--- verif/tb.sv
/* tb: self-checking bench of otgsw_regs against a bench model.
   assumes: otgsw_host drives the register port. */
`timescale 1ns/1ps
module tb;
    import otgsw_pkg::*;
    localparam logic [7:0] SRC = 8'h5a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vbus_valid = 1'b0;
    otgsw_sw_stat_s sw1_stat = 2'b10;
    otgsw_sw_stat_s sw2_stat = 2'b10;
    otgsw_req_s req;
    logic [7:0] rdata, d, ctl, en, v;
    logic sw1_on, sw2_on, sw3_on, dbl, irq_n, flag;
    logic [31:0] seed = 32'h7dc0995b;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    otgsw_host host (.clk(clk), .req(req), .rdata(rdata));
    otgsw_regs #(.SOURCE_ADDR(SRC)) dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .vbus_valid(vbus_valid), .sw1_stat(sw1_stat), .sw2_stat(sw2_stat),
        .switch1_on(sw1_on), .switch2_on(sw2_on), .switch3_on(sw3_on),
        .switch3_limit_double(dbl), .irq_n(irq_n));
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    // model of the status register
    function automatic logic [7:0] eb0();
        return ctl | {3'b000, sw1_stat.startup_ok & ~sw1_stat.in_limit,
            sw2_stat.startup_ok & ~sw2_stat.in_limit, flag, 1'b0, vbus_valid};
    endfunction : eb0
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask : rdc
    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            errors = errors + 1;
            conclude();
        end
    end
    initial
    begin
        ctl = 8'h00;
        flag = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(OTGSW_ADDR_STATUS_CTRL, eb0());
        rdc(OTGSW_ADDR_IRQ_SOURCE, 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            v = xs();
            sw1_stat <= v[1:0];
            sw2_stat <= v[3:2];
            host.wr(OTGSW_ADDR_STATUS_CTRL, v);
            ctl = v & 8'he2;
            // let the write edge settle before looking at the controls
            #1;
            chk({4'h0, sw1_on, sw2_on, sw3_on, dbl}, {4'h0, ctl[7:5], ctl[1]});
            v = xs();
            host.wr(OTGSW_ADDR_IRQ_ENABLE, v);
            en = v & 8'hce;
            v = {xs() | 8'h03};
            host.wr(v, xs());
            rdc(v, 8'h00);
            rdc(OTGSW_ADDR_STATUS_CTRL, eb0());
            rdc(OTGSW_ADDR_IRQ_ENABLE, en);
        end
        @(posedge clk);
        sw1_stat <= 2'b10;
        sw2_stat <= 2'b10;
        host.wr(OTGSW_ADDR_IRQ_ENABLE, 8'hc2);
        rdc(OTGSW_ADDR_STATUS_CTRL, eb0());
        for (int i = 0; i < 4; i++)
        begin
            v = 8'hc0 >> (2 * (i / 2));
            if (i == 2)
                host.wr(OTGSW_ADDR_IRQ_ENABLE, 8'hc0);
            if (i == 3)
                host.wr(OTGSW_ADDR_IRQ_ENABLE, 8'h02);
            @(posedge clk);
            vbus_valid <= ~vbus_valid;
            repeat (6) @(posedge clk);
            chk({7'h00, irq_n}, {7'h00, i > 1});
            rdc(OTGSW_ADDR_IRQ_SOURCE, i > 1 ? 8'h00 : SRC);
            flag = i < 3;
            rdc(OTGSW_ADDR_STATUS_CTRL, eb0());
            flag = 1'b0;
            repeat (3) @(posedge clk);
            chk({7'h00, irq_n}, 8'h01);
            rdc(OTGSW_ADDR_STATUS_CTRL, eb0());
        end
        for (int i = 0; i < 2; i++)
        begin
            host.wr(OTGSW_ADDR_IRQ_ENABLE, i ? 8'h04 : 8'h08);
            if (i)
                sw2_stat <= 2'b11;
            else
                sw1_stat <= 2'b11;
            repeat (4) @(posedge clk);
            chk({7'h00, irq_n}, 8'h00);
            rdc(OTGSW_ADDR_IRQ_SOURCE, SRC);
            rdc(OTGSW_ADDR_STATUS_CTRL, eb0());
            repeat (3) @(posedge clk);
            chk({7'h00, irq_n}, 8'h01);
            sw1_stat <= 2'b10;
            sw2_stat <= 2'b10;
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OTGSW_ADDR_IRQ_ENABLE, OTGSW_RST_IRQ_ENABLE);
        ctl = 8'h00;
        chk({3'h0, sw1_on, sw2_on, sw3_on, dbl, irq_n}, 8'h01);
        rdc(OTGSW_ADDR_STATUS_CTRL, eb0());
        conclude();
    end
endmodule : tb
